// file: verilog/ddc_pkg.sv
// ddc_pkg: register map, field positions, reset values and timing constants of the diagnostic config bank
package ddc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          REG_W         = 22;
    localparam int          ADDR_W        = 5;
    localparam logic [4:0]  GCT_ADDR      = 5'h0a;
    localparam logic [4:0]  DDE_ADDR      = 5'h10;
    localparam logic [21:0] GCT_RESET     = 22'h0a0200;
    localparam logic [21:0] DDE_RESET     = 22'h10005d;

    // ----------------------------------------------------------------
    // common field positions
    // ----------------------------------------------------------------
    localparam int          ALARM_BIT     = 21;
    localparam int          ADDR_HI       = 20;
    localparam int          ADDR_LO       = 16;

    // general_config_two fields
    localparam int          BCAST_BIT     = 10;
    localparam int          TMO_BIT       = 9;
    // writable bits of general_config_two: [14:0] of the [15:0] field as printed (bit 15 reads zero)
    localparam logic [21:0] GCT_WMASK     = 22'h007fff;

    // digital_diagnostic_enables fields
    localparam int          LATCH_BIT     = 6;
    localparam int          INV_BIT       = 4;
    localparam int          CALCRC_BIT    = 3;
    localparam int          FREQ_BIT      = 2;
    localparam int          SPICRC_BIT    = 0;
    // bits [15:7] read zero, the rest of [6:0] are writable
    localparam logic [21:0] DDE_WMASK     = 22'h00007f;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint      CLK_HZ        = 10000000;
    localparam longint      TMO_LONG_US   = 25000;
    localparam longint      TMO_SHORT_US  = 6500;
    localparam longint      TMO_LONG_CYC  = (TMO_LONG_US * CLK_HZ) / 1000000;
    localparam longint      TMO_SHORT_CYC = (TMO_SHORT_US * CLK_HZ) / 1000000;
    localparam int          TMO_CNT_W     = 18;
    localparam int          CODE_W        = 14;

endpackage

// file: verilog/ddc_fault_timer.sv
// ddc_fault_timer: qualifies an analog fault level for a selectable timeout before reporting it
`timescale 1ns/100ps
module ddc_fault_timer #(
    parameter int CNT_W = 18
) (
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    // fault level and limit
    input  wire logic             fault_in,
    input  wire logic [CNT_W-1:0] limit_in,
    // qualified result
    output logic                  result_out
);

    logic [CNT_W-1:0] count;

    // result follows the fault only after it has held for limit cycles, either way
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count      <= '0;
            result_out <= 1'b0;
        end else if (clk_en_in) begin
            if (fault_in == result_out) begin
                count <= '0;
            end else if (count >= limit_in - 1'b1) begin
                count      <= '0;
                result_out <= fault_in;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

endmodule

// file: verilog/ddc_config_bank.sv
// ddc_config_bank: general_config_two and digital_diagnostic_enables registers with their control effects
`timescale 1ns/100ps

// Function
// - broadcast bit makes load ignore address pins
// - timeout bit selects 25 ms or 6.5 ms
// - enables register at 0x10, reset 0x10005d
// - bit 21 reads live alarm pin level
// - latch monitor flags code mismatch when enabled
// - enable bit gates inverse code check
// - enable bit gates calibration memory crc check
// - enable bit gates master clock rate monitor
// - enable bit turns serial frame crc on
// - config register at 0x0a, reset 0x0a0200
module ddc_config_bank
    import ddc_pkg::*;
#(
    parameter int CNT_W = ddc_pkg::TMO_CNT_W
) (
    // clock, enable and reset
    input  wire logic                        core_clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        clk_en_in,
    // register access from the serial frame decoder
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    input  wire logic [ddc_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [ddc_pkg::REG_W-1:0]   reg_wdata_in,
    output logic      [ddc_pkg::REG_W-1:0]   reg_rdata_out,
    output logic                             reg_rvalid_out,
    // software load command
    input  wire logic                        software_load_command_in,
    input  wire logic [1:0]                  load_addr_in,
    input  wire logic [1:0]                  hw_addr_pins_in,
    output logic                             load_converter_update_out,
    // analog fault and alarm pin
    input  wire logic                        analog_fault_in,
    input  wire logic                        alarm_pin_in,
    output logic                             analog_check_result_out,
    // converter code monitor
    input  wire logic [ddc_pkg::CODE_W-1:0]  dac_code_gen_in,
    input  wire logic [ddc_pkg::CODE_W-1:0]  dac_code_latch_in,
    input  wire logic                        latch_error_clear_in,
    output logic                             latch_monitor_error_out,
    // enables to the diagnostic engines
    output logic                             inverse_check_enable_out,
    output logic                             cal_crc_enable_out,
    output logic                             clock_rate_monitor_enable_out,
    output logic                             spi_crc_enable_out
);

    import ddc_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // refused at elaboration: a counter too narrow would wrap before the long timeout
    if (CNT_W < 1 || CNT_W > 31 || TMO_LONG_CYC >= (64'h1 << CNT_W)) begin : g_cnt_w_check
        $error("ddc_config_bank: CNT_W too narrow for the fault timeout");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [REG_W-1:0] general_config_two;
    logic [REG_W-1:0] digital_diagnostic_enables;
    logic [CNT_W-1:0] tmo_limit;

    // masked write merge: only writable bits change
    function automatic logic [REG_W-1:0] merge_wr(input logic [REG_W-1:0] old_v,
                                                  input logic [REG_W-1:0] new_v,
                                                  input logic [REG_W-1:0] mask);
        merge_wr = (old_v & ~mask) | (new_v & mask);
    endfunction

    // read-back image: alarm level, own address, stored writable bits
    function automatic logic [REG_W-1:0] read_image(input logic [REG_W-1:0] stored,
                                                    input logic [REG_W-1:0] mask,
                                                    input logic [4:0]       addr,
                                                    input logic             alarm);
        logic [REG_W-1:0] img;
        img                  = stored & mask;
        img[ADDR_HI:ADDR_LO] = addr;
        img[ALARM_BIT]       = alarm;
        read_image           = img;
    endfunction

    // general_config_two; bits 21:16 never stored from a write
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            general_config_two <= GCT_RESET;
        end else if (clk_en_in && reg_wr_in && reg_addr_in == GCT_ADDR) begin
            general_config_two <= merge_wr(general_config_two, reg_wdata_in, GCT_WMASK);
        end
    end

    // digital_diagnostic_enables; reserved 15:7 read zero
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            digital_diagnostic_enables <= DDE_RESET;
        end else if (clk_en_in && reg_wr_in && reg_addr_in == DDE_ADDR) begin
            digital_diagnostic_enables <= merge_wr(digital_diagnostic_enables, reg_wdata_in, DDE_WMASK);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // alarm pin is sampled at the read so bit 21 is always current
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            reg_rdata_out  <= '0;
            reg_rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    GCT_ADDR: begin
                        reg_rdata_out <= read_image(general_config_two, GCT_WMASK, GCT_ADDR, alarm_pin_in);
                    end
                    DDE_ADDR: begin
                        reg_rdata_out <= read_image(digital_diagnostic_enables, DDE_WMASK, DDE_ADDR, alarm_pin_in);
                    end
                    default: begin
                        reg_rdata_out <= '0; // other registers live elsewhere
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // software load
    // ----------------------------------------------------------------
    // broadcast lets one command update every device on a shared frame
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            load_converter_update_out <= 1'b0;
        end else if (clk_en_in) begin
            load_converter_update_out <= software_load_command_in &&
                (general_config_two[BCAST_BIT] || load_addr_in == hw_addr_pins_in);
        end
    end

    // ----------------------------------------------------------------
    // fault timeout
    // ----------------------------------------------------------------
    // limit registered so the timer input comes from a flop, one cycle lag is harmless
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tmo_limit <= CNT_W'(TMO_SHORT_CYC);
        end else if (clk_en_in) begin
            tmo_limit <= general_config_two[TMO_BIT] ? CNT_W'(TMO_SHORT_CYC) : CNT_W'(TMO_LONG_CYC);
        end
    end

    ddc_fault_timer #(
        .CNT_W (CNT_W)
    ) u_fault_timer (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .clk_en_in   (clk_en_in),
        .fault_in    (analog_fault_in),
        .limit_in    (tmo_limit),
        .result_out  (analog_check_result_out)
    );

    // ----------------------------------------------------------------
    // latch monitor
    // ----------------------------------------------------------------
    // sticky flag; a new mismatch beats a clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            latch_monitor_error_out <= 1'b0;
        end else if (clk_en_in) begin
            if (digital_diagnostic_enables[LATCH_BIT] && dac_code_gen_in != dac_code_latch_in) begin
                latch_monitor_error_out <= 1'b1;
            end else if (latch_error_clear_in) begin
                latch_monitor_error_out <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // enables to the engines
    // ----------------------------------------------------------------
    // engines gate their own flags on these, so a clear enable blocks the flag
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            inverse_check_enable_out      <= DDE_RESET[INV_BIT];
            cal_crc_enable_out            <= DDE_RESET[CALCRC_BIT];
            clock_rate_monitor_enable_out <= DDE_RESET[FREQ_BIT];
            spi_crc_enable_out            <= DDE_RESET[SPICRC_BIT];
        end else if (clk_en_in) begin
            inverse_check_enable_out      <= digital_diagnostic_enables[INV_BIT];
            cal_crc_enable_out            <= digital_diagnostic_enables[CALCRC_BIT];
            clock_rate_monitor_enable_out <= digital_diagnostic_enables[FREQ_BIT];
            spi_crc_enable_out            <= digital_diagnostic_enables[SPICRC_BIT];
        end
    end

endmodule

// file: bench/ddc_config_bank_monitor.sv
// ddc_config_bank_monitor: port-level assertions for the config bank
`timescale 1ns/100ps
module ddc_config_bank_monitor
    import ddc_pkg::*;
(
    // clock and reset
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        clk_en_in,
    // register access
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [4:0]  reg_addr_in,
    input wire logic [21:0] reg_wdata_in,
    input wire logic [21:0] reg_rdata_out,
    input wire logic        reg_rvalid_out,
    // load, fault and code monitor
    input wire logic        alarm_pin_in,
    input wire logic        software_load_command_in,
    input wire logic [1:0]  load_addr_in,
    input wire logic [1:0]  hw_addr_pins_in,
    input wire logic        load_converter_update_out,
    input wire logic        analog_fault_in,
    input wire logic        analog_check_result_out,
    input wire logic [13:0] dac_code_gen_in,
    input wire logic [13:0] dac_code_latch_in,
    input wire logic        latch_monitor_error_out,
    input wire logic        inverse_check_enable_out,
    input wire logic        spi_crc_enable_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // helpers keep $past on plain signals
    logic       mism;
    logic       hit;
    logic       mrd;
    logic [1:0] en_bits;
    assign mism = dac_code_gen_in != dac_code_latch_in;
    assign hit = clk_en_in && software_load_command_in && load_addr_in == hw_addr_pins_in;
    assign mrd = clk_en_in && reg_rd_in && (reg_addr_in == GCT_ADDR || reg_addr_in == DDE_ADDR);
    assign en_bits = {reg_wdata_in[INV_BIT], reg_wdata_in[SPICRC_BIT]};
    rd_alarm_a: assert property (mrd |=> reg_rdata_out[ALARM_BIT] == $past(alarm_pin_in))
        else $error("alarm bit not live on read");
    rd_addr_a: assert property (mrd |=> reg_rvalid_out && reg_rdata_out[20:16] == $past(reg_addr_in))
        else $error("read image lacks own address");
    load_match_a: assert property (hit |=> load_converter_update_out)
        else $error("matching load gave no update");
    load_idle_a: assert property (clk_en_in && !software_load_command_in |=> !load_converter_update_out)
        else $error("update without load command");
    latch_cause_a: assert property ($rose(latch_monitor_error_out) |-> $past(mism))
        else $error("latch error without code mismatch");
    enable_reset_a: assert property ($fell(rst_in) |-> inverse_check_enable_out && spi_crc_enable_out)
        else $error("enables not set after reset");
    enable_follow_a: assert property (clk_en_in && reg_wr_in && reg_addr_in == DDE_ADDR
        |-> ##2 {inverse_check_enable_out, spi_crc_enable_out} == $past(en_bits, 2))
        else $error("enables do not follow write");
    fault_cause_a: assert property ($changed(analog_check_result_out)
        |-> analog_check_result_out == $past(analog_fault_in))
        else $error("fault result moved against input");
endmodule

// file: bench/ddc_host_model.sv
// ddc_host_model: register host issuing one-cycle write and read strobes
`timescale 1ns/100ps
module ddc_host_model (
    // clock
    input  wire logic        core_clk_in,
    // strobes toward the bank
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    output logic [4:0]       reg_addr_out,
    output logic [21:0]      reg_wdata_out,
    // read answer
    input  wire logic [22:0] reg_ans_in
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 5'h00;
        reg_wdata_out = 22'h000000;
    end
    // frames are taken as carrying good crc while that check is on; released lines show the inverse
    task automatic wr(input logic [4:0] a, input logic [21:0] d);
        @(negedge core_clk_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge core_clk_in);
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    // answer is taken in the cycle after the read edge, while the valid flag stands
    task automatic rd(input logic [4:0] a, output logic [22:0] q);
        @(negedge core_clk_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge core_clk_in);
        q = reg_ans_in;
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
    endtask
endmodule

// file: bench/ddc_config_bank_tb.sv
// ddc_config_bank_tb: self-checking bench for the diagnostic config bank
`timescale 1ns/100ps
module ddc_config_bank_tb;
    import ddc_pkg::*;
    typedef struct packed {
        logic [4:0]  addr;
        logic [21:0] wdata;
        logic [15:0] lo;
        logic [3:0]  en;
    } ddc_row_s;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        cmd = 1'b0;
    logic        fault = 1'b0;
    logic        alarm = 1'b0;
    logic        clr = 1'b0;
    logic [1:0]  laddr = 2'b00;
    logic [1:0]  pins = 2'b01;
    logic [13:0] gen = 14'h0000;
    logic [13:0] lat = 14'h0000;
    logic        wr, rd, rv, upd, res, lerr;
    logic [3:0]  en;
    logic [4:0]  addr;
    logic [21:0] wdata, rdata;
    logic [22:0] got;
    int          n_fail = 0;
    int          check_count = 0;
    // enables ordered inverse, cal crc, clock rate, frame crc; 0x05 is unmapped
    ddc_row_s rows [7] = '{'{5'h10, 22'h3fffff, 16'h007f, 4'hf}, '{5'h10, 22'h000000, 16'h0000, 4'h0},
        '{5'h10, 22'h000011, 16'h0011, 4'h9}, '{5'h10, 22'h00002c, 16'h002c, 4'h6},
        '{5'h0a, 22'h3fffff, 16'h7fff, 4'h6}, '{5'h05, 22'h3fffff, 16'h0000, 4'h6},
        '{5'h0a, 22'h000600, 16'h0600, 4'h6}};
    initial forever #50 clk = ~clk;
    ddc_config_bank dut (.core_clk_in(clk), .rst_in(rst), .clk_en_in(clk_en), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rv),
        .software_load_command_in(cmd), .load_addr_in(laddr), .hw_addr_pins_in(pins),
        .load_converter_update_out(upd), .analog_fault_in(fault), .alarm_pin_in(alarm),
        .analog_check_result_out(res), .dac_code_gen_in(gen), .dac_code_latch_in(lat),
        .latch_error_clear_in(clr), .latch_monitor_error_out(lerr), .inverse_check_enable_out(en[3]),
        .cal_crc_enable_out(en[2]), .clock_rate_monitor_enable_out(en[1]), .spi_crc_enable_out(en[0]));
    ddc_host_model host (.core_clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_ans_in({rv, rdata}));
    task automatic check(input string name, input logic [22:0] seen, input logic [22:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one load pulse, update looked at in the cycle after it is taken
    task automatic load(input logic [1:0] la, input logic exp);
        laddr = la;
        cmd = 1'b1;
        @(negedge clk);
        cmd = 1'b0;
        check("load update", upd, exp);
        @(negedge clk);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check("reset enables", en, 4'hf);
        host.rd(GCT_ADDR, got);
        check("gct reset", got, {1'b1, 22'h0a0200});
        alarm = 1'b1;
        host.rd(DDE_ADDR, got);
        check("dde reset", got, {1'b1, 22'h30005d});
        foreach (rows[i]) begin
            alarm = i[0];
            host.wr(rows[i].addr, rows[i].wdata);
            host.rd(rows[i].addr, got);
            check("readback", got, {1'b1, (rows[i].addr == GCT_ADDR || rows[i].addr == DDE_ADDR) ?
                {alarm, rows[i].addr, rows[i].lo} : 22'h000000});
            check("enables", en, rows[i].en);
        end
        load(2'b10, 1'b1);
        host.wr(GCT_ADDR, 22'h000200);
        load(2'b10, 1'b0);
        load(2'b01, 1'b1);
        clk_en = 1'b0;
        load(2'b01, 1'b0);
        clk_en = 1'b1;
        gen = 14'h1234;
        lat = 14'h1235;
        repeat (3) @(negedge clk);
        check("latch off", lerr, 1'b0);
        host.wr(DDE_ADDR, 22'h00005d);
        repeat (2) @(negedge clk);
        check("latch set", lerr, 1'b1);
        clr = 1'b1;
        @(negedge clk);
        check("set beats clear", lerr, 1'b1);
        lat = gen;
        @(negedge clk);
        clr = 1'b0;
        check("latch clear", lerr, 1'b0);
        // mid-run reset after the enables and timeout select were moved off their reset values
        host.wr(DDE_ADDR, 22'h000000);
        host.wr(GCT_ADDR, 22'h000400);
        check("enables off", en, 4'h0);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check("rerun enables", en, 4'hf);
        check("rerun latch", lerr, 1'b0);
        host.rd(GCT_ADDR, got);
        check("rerun gct", got, {1'b1, 22'h0a0200});
        fault = 1'b1;
        repeat (64990) @(negedge clk);
        check("fault early", res, 1'b0);
        repeat (20) @(negedge clk);
        check("fault late", res, 1'b1);
        final_report();
    end
    // hang guard well beyond the 65k-cycle fault wait
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule
bind ddc_config_bank ddc_config_bank_monitor mon (
    .core_clk_in               (core_clk_in),
    .rst_in                    (rst_in),
    .clk_en_in                 (clk_en_in),
    .reg_wr_in                 (reg_wr_in),
    .reg_rd_in                 (reg_rd_in),
    .reg_addr_in               (reg_addr_in),
    .reg_wdata_in              (reg_wdata_in),
    .reg_rdata_out             (reg_rdata_out),
    .reg_rvalid_out            (reg_rvalid_out),
    .alarm_pin_in              (alarm_pin_in),
    .software_load_command_in  (software_load_command_in),
    .load_addr_in              (load_addr_in),
    .hw_addr_pins_in           (hw_addr_pins_in),
    .load_converter_update_out (load_converter_update_out),
    .analog_fault_in           (analog_fault_in),
    .analog_check_result_out   (analog_check_result_out),
    .dac_code_gen_in           (dac_code_gen_in),
    .dac_code_latch_in         (dac_code_latch_in),
    .latch_monitor_error_out   (latch_monitor_error_out),
    .inverse_check_enable_out  (inverse_check_enable_out),
    .spi_crc_enable_out        (spi_crc_enable_out)
);
